// >>> shared/luc_consts.svh
/*
 * Constants for the laser user I/O control block: timing counts,
 * register offsets, field positions and reset values.
 * Assumes a 10 MHz aclk and AXI4-Lite register access.
 */
// How it works
// - While reset/start request is asserted, lasing stays disabled.
// - Releasing the request lights ready and starts five-second enable countdown.
// - Lasing is permitted only while the remote interlock is asserted.
// - Shutter opens on request only with interlock asserted and ready on.
// - Emission indicator output closes only while a beam is being emitted.
// - Overheat indicator output closes on over-temperature or no-strike.
// - Ready output closes while enabled, open while disabled.
// - First closing of ready inhibits lasing for five seconds.
// - Shutter indicator closes only with interlock and shutter request present.
// - Interlock-open output closes while interlock circuit open, lasing off.
// - Controller drives PWM near 5 kHz, never above 100 kHz; the bench model luc_plc drives 50 kHz.
// - Interlock loss closes shutter, drops ready and shutter, cuts RF.
// - Interlock faults are not latched; re-assertion restarts the delay.
// - Output power follows the modulation duty cycle.
`ifndef LUC_CONSTS_SVH
`define LUC_CONSTS_SVH

`define LUC_CLK_HZ        10000000
`define LUC_DELAY_S       5
`define LUC_DELAY_CYC     (`LUC_DELAY_S * `LUC_CLK_HZ)
`define LUC_CNT_W         26

`define LUC_OFF_CTRL      32'h0000_0000
`define LUC_OFF_STAT      32'h0000_0004
`define LUC_OFF_PWM_HI    32'h0000_0008
`define LUC_OFF_PWM_PER   32'h0000_000C

`define LUC_CTRL_FAULT_CLR 0
`define LUC_CTRL_RESET    32'h0000_0000

`define LUC_ST_STATE_LO   0
`define LUC_ST_READY      2
`define LUC_ST_EMIT       3
`define LUC_ST_SHUT       4
`define LUC_ST_OVERHEAT   5
`define LUC_ST_NOSTRIKE   6
`define LUC_ST_INTLK      7

`define LUC_RESP_OKAY     2'b00
`define LUC_RESP_SLVERR   2'b10

`endif

// >>> shared/luc_pkg.sv
/*
 * Types for the laser user I/O control block.
 * Assumes luc_consts.svh supplies the numeric constants.
 */
package luc_pkg;
	typedef enum logic [1:0] {
		LUC_DISABLED,
		LUC_COUNTING,
		LUC_ENABLED
	} luc_state_e;
endpackage

// >>> hdl/luc_top.sv
/*
 * Enable, interlock, shutter and status logic behind the user I/O port,
 * with an AXI4-Lite slave for status and PWM measurement.
 * Assumes isolated inputs are asynchronous and active high after the
 * optocouplers; switched outputs are modelled as a close level plus
 * output enable, high while the switch conducts.
 */
`timescale 1ns/10ps
`include "luc_consts.svh"
module luc_top
#(
	parameter int unsigned DELAY_CYC = `LUC_DELAY_CYC
)
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Isolated user inputs
	input  wire logic        start_req_in,
	input  wire logic        interlock_in,
	input  wire logic        shutter_req_in,
	input  wire logic        pwm_in,
	// Internal sensors
	input  wire logic        overheat,
	input  wire logic        no_strike,
	// Internal actuators
	output logic             shutter_open,
	output logic             rf_power_en,
	output logic             rf_drive,
	// Switched status outputs, close level and enable
	output logic             emission_indicator,
	output logic             emission_indicator_oe,
	output logic             overheat_indicator,
	output logic             overheat_indicator_oe,
	output logic             ready_out,
	output logic             ready_out_oe,
	output logic             shutter_indicator,
	output logic             shutter_indicator_oe,
	output logic             intlk_open_out,
	output logic             intlk_open_out_oe,
	// AXI4-Lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
		hit = (a[7:2] == o[7:2]) && (a[31:8] == 24'h00_0000);
	endfunction

	logic [3:0]             sync1;
	logic [3:0]             sync2;
	logic                   req_s;
	logic                   intlk_s;
	logic                   shreq_s;
	logic                   pwm_s;
	logic [1:0]             sens1;
	logic [1:0]             sens2;
	luc_pkg::luc_state_e    state;
	logic [`LUC_CNT_W-1:0]  delay_cnt;
	logic                   delay_done;
	logic                   ready_on;
	logic                   emission_indicator_en;
	logic                   emitting;
	logic                   nostrike_seen;
	logic                   pwm_d;
	logic [15:0]            pwm_hi_cnt;
	logic [15:0]            pwm_per_cnt;
	logic [15:0]            pwm_hi;
	logic [15:0]            pwm_per;
	logic                   aw_held;
	logic                   w_held;
	logic [31:0]            aw_addr;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;
	logic                   fault_clr;
	logic [31:0]            rd_word;
	logic                   rd_ok;

	// Two stages before any use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sens1 <= 2'b00;
			sens2 <= 2'b00;
		end
		else
		begin
			sync1 <= {pwm_in, shutter_req_in, interlock_in, start_req_in};
			sync2 <= sync1;
			sens1 <= {no_strike, overheat};
			sens2 <= sens1;
		end
	end

	assign req_s   = sync2[0];
	assign intlk_s = sync2[1];
	assign shreq_s = sync2[2];
	assign pwm_s   = sync2[3];

	// Ready follows released request and present interlock, unlatched
	assign ready_on   = !req_s && intlk_s;
	assign delay_done = (delay_cnt == `LUC_CNT_W'(DELAY_CYC - 1));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state     <= luc_pkg::LUC_DISABLED;
			delay_cnt <= '0;
		end
		else
		begin
			case (state)
				luc_pkg::LUC_DISABLED:
				begin
					delay_cnt <= '0;
					if (ready_on)
						state <= luc_pkg::LUC_COUNTING;
				end
				luc_pkg::LUC_COUNTING:
				begin
					if (!ready_on)
					begin
						state     <= luc_pkg::LUC_DISABLED;
						delay_cnt <= '0;
					end
					else if (delay_done)
						state <= luc_pkg::LUC_ENABLED;
					else
						delay_cnt <= delay_cnt + 1'b1;
				end
				luc_pkg::LUC_ENABLED:
				begin
					if (!ready_on)
						state <= luc_pkg::LUC_DISABLED;
				end
				default:
					state <= luc_pkg::LUC_DISABLED;
			endcase
		end
	end

	// Emission enable drops the instant the request or interlock goes
	assign emission_indicator_en = (state == luc_pkg::LUC_ENABLED) && ready_on;

	// No-strike is sticky until software clears it; set wins over clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			nostrike_seen <= 1'b0;
		else if (sens2[1])
			nostrike_seen <= 1'b1;
		else if (fault_clr)
			nostrike_seen <= 1'b0;
	end

	// Registered outputs; only constants under reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shutter_open       <= 1'b0;
			rf_power_en        <= 1'b0;
			rf_drive           <= 1'b0;
			emitting           <= 1'b0;
			overheat_indicator <= 1'b0;
			ready_out          <= 1'b0;
			shutter_indicator  <= 1'b0;
			intlk_open_out     <= 1'b1;
		end
		else
		begin
			shutter_open       <= shreq_s && intlk_s && ready_on;
			rf_power_en        <= ready_on;
			rf_drive           <= emission_indicator_en && pwm_s;
			emitting           <= emission_indicator_en && pwm_s;
			overheat_indicator <= sens2[0] || nostrike_seen;
			ready_out          <= ready_on;
			shutter_indicator  <= shreq_s && intlk_s && ready_on;
			intlk_open_out     <= !intlk_s;
		end
	end

	assign emission_indicator    = emitting;
	assign emission_indicator_oe = emitting;
	assign overheat_indicator_oe = overheat_indicator;
	assign ready_out_oe          = ready_out;
	assign shutter_indicator_oe  = shutter_indicator;
	assign intlk_open_out_oe     = intlk_open_out;

	// Duty measurement lets software check the command against
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwm_d       <= 1'b0;
			pwm_hi_cnt  <= 16'h0000;
			pwm_per_cnt <= 16'h0000;
			pwm_hi      <= 16'h0000;
			pwm_per     <= 16'h0000;
		end
		else
		begin
			pwm_d <= pwm_s;
			if (pwm_s && !pwm_d)
			begin
				pwm_hi      <= pwm_hi_cnt;
				pwm_per     <= pwm_per_cnt;
				pwm_hi_cnt  <= 16'h0001;
				pwm_per_cnt <= 16'h0001;
			end
			else
			begin
				if (pwm_per_cnt != 16'hFFFF)
					pwm_per_cnt <= pwm_per_cnt + 16'h0001;
				if (pwm_s && pwm_hi_cnt != 16'hFFFF)
					pwm_hi_cnt <= pwm_hi_cnt + 16'h0001;
			end
		end
	end

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 32'h0000_0000;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LUC_RESP_OKAY;
			fault_clr    <= 1'b0;
		end
		else
		begin
			fault_clr <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (hit(aw_addr, `LUC_OFF_CTRL))
				begin
					s_axi_bresp <= `LUC_RESP_OKAY;
					fault_clr   <= w_strb[0]
						&& w_data[`LUC_CTRL_FAULT_CLR];
				end
				else if (hit(aw_addr, `LUC_OFF_STAT)
					|| hit(aw_addr, `LUC_OFF_PWM_HI)
					|| hit(aw_addr, `LUC_OFF_PWM_PER))
					s_axi_bresp <= `LUC_RESP_OKAY;
				else
					s_axi_bresp <= `LUC_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (hit(s_axi_araddr, `LUC_OFF_CTRL))
			rd_word = `LUC_CTRL_RESET;
		else if (hit(s_axi_araddr, `LUC_OFF_STAT))
		begin
			rd_word[`LUC_ST_STATE_LO +: 2] = state;
			rd_word[`LUC_ST_READY]    = ready_out;
			rd_word[`LUC_ST_EMIT]     = emitting;
			rd_word[`LUC_ST_SHUT]     = shutter_indicator;
			rd_word[`LUC_ST_OVERHEAT] = sens2[0];
			rd_word[`LUC_ST_NOSTRIKE] = nostrike_seen;
			rd_word[`LUC_ST_INTLK]    = intlk_s;
		end
		else if (hit(s_axi_araddr, `LUC_OFF_PWM_HI))
			rd_word[15:0] = pwm_hi;
		else if (hit(s_axi_araddr, `LUC_OFF_PWM_PER))
			rd_word[15:0] = pwm_per;
		else
			rd_ok = 1'b0;
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `LUC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_ok ? `LUC_RESP_OKAY : `LUC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // luc_top

// >>> sim/luc_top_checker.sv
/* Port assertions for the laser user I/O control block.
   Assumes DELAY_CYC matches the bound instance. */
`timescale 1ns/10ps
module luc_top_checker
#(
	parameter int unsigned DELAY_CYC = 20
)
(
	// Clock, reset, inputs
	input wire logic aclk, aresetn, start_req_in, interlock_in, overheat,
	// Status and drive
	input wire logic shutter_open, rf_power_en, rf_drive, ready_out,
	input wire logic emission_indicator, emission_indicator_oe,
	input wire logic shutter_indicator, shutter_indicator_oe,
	input wire logic overheat_indicator, ready_out_oe, intlk_open_out,
	// Bus handshakes
	input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
	input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid,
	input wire logic s_axi_arready, s_axi_rvalid
);
	logic [2:0]  up;
	logic [31:0] on_cnt;
	// Sync stages hold stale levels just after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!ready_out)
			on_cnt <= 32'h0000_0000;
		else
			on_cnt <= on_cnt + 32'h0000_0001;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_emission_indicator_gated: assert property (rf_drive |-> on_cnt >= DELAY_CYC)
		else $error("lasing before enable delay");
	a_ready_inhibit: assert property ($rose(ready_out) |-> !rf_drive [*8])
		else $error("lasing right after ready");
	a_req_holds: assert property (start_req_in [*5] |-> !ready_out && !rf_drive)
		else $error("enabled during start request");
	a_intlk_loss: assert property (!interlock_in [*5] |-> !ready_out
		&& !shutter_open && !shutter_indicator && intlk_open_out)
		else $error("interlock loss not honoured");
	a_emit_ready: assert property (emission_indicator |-> ready_out
		&& !intlk_open_out && rf_power_en == ready_out)
		else $error("emission without ready");
	a_shut_ready: assert property (shutter_open || shutter_indicator
		|-> ready_out)
		else $error("shutter open without ready");
	a_oe_follow: assert property ({ready_out_oe, emission_indicator_oe,
		shutter_indicator_oe} == {ready_out, emission_indicator,
		shutter_indicator})
		else $error("switch enable differs from level");
	a_hot_shown: assert property ((up == 3'h7 && overheat) [*5]
		|-> overheat_indicator)
		else $error("overheat not shown");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	// Both halves are held first, so the response comes one edge later
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule // luc_top_checker

bind luc_top luc_top_checker #(.DELAY_CYC(DELAY_CYC)) luc_top_checker_inst (
	.aclk, .aresetn, .start_req_in, .interlock_in, .overheat, .shutter_open,
	.rf_power_en, .rf_drive, .ready_out, .emission_indicator,
	.emission_indicator_oe, .shutter_indicator, .shutter_indicator_oe,
	.overheat_indicator, .ready_out_oe, .intlk_open_out, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// >>> sim/luc_plc.sv
/* Machine controller model driving the user inputs.
   Assumes the bench sets its commands at rising edges. */
`timescale 1ns/10ps
module luc_plc
#(
	parameter int PWM_PER = 200,
	parameter int PWM_HI  = 100
)
(
	// Commands from the bench
	input wire logic aclk, hold_start, intlk_ok, shut_ok, pwm_cw, pwm_run,
	// User inputs of the block
	output logic     start_req_in, interlock_in, shutter_req_in, pwm_in
);
	int cnt = 0;
	initial
	begin
		{start_req_in, interlock_in, shutter_req_in, pwm_in} = 4'h0;
	end
	// 50 kHz keeps below the 100 kHz ceiling
	always @(posedge aclk)
	begin
		cnt <= (cnt == PWM_PER - 1) ? 0 : cnt + 1;
		start_req_in <= hold_start;
		interlock_in <= intlk_ok;
		shutter_req_in <= shut_ok;
		pwm_in <= pwm_cw | (pwm_run & (cnt < PWM_HI));
	end
endmodule // luc_plc

// >>> sim/luc_top_tb.sv
/* Self-checking bench for the user I/O control block.
   Assumes the partner model drives the user pins. */
`timescale 1ns/10ps
`include "luc_consts.svh"
module luc_top_tb;
	logic aclk = 0, aresetn = 0, hold_start = 1, intlk_ok = 1, shut_ok = 1;
	logic pwm_cw = 1, pwm_run = 0, overheat = 0, no_strike = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic start_req_in, interlock_in, shutter_req_in, pwm_in, shutter_open;
	logic rf_power_en, rf_drive, emission_indicator, emission_indicator_oe;
	logic overheat_indicator, overheat_indicator_oe, ready_out, ready_out_oe;
	logic shutter_indicator, shutter_indicator_oe, intlk_open_out;
	logic intlk_open_out_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int fail_count = 0, compares = 0, n;
	always #50 aclk = ~aclk;
	luc_plc luc_plc_inst (.aclk, .hold_start, .intlk_ok, .shut_ok, .pwm_cw,
		.pwm_run, .start_req_in, .interlock_in, .shutter_req_in, .pwm_in);
	luc_top #(.DELAY_CYC(20)) luc_top_inst (.aclk, .aresetn, .start_req_in,
		.interlock_in, .shutter_req_in, .pwm_in, .overheat, .no_strike,
		.shutter_open, .rf_power_en, .rf_drive, .emission_indicator,
		.emission_indicator_oe, .overheat_indicator, .overheat_indicator_oe,
		.ready_out, .ready_out_oe, .shutter_indicator, .shutter_indicator_oe,
		.intlk_open_out, .intlk_open_out_oe, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic w(int c);
		repeat (c) @(posedge aclk);
	endtask
	// Outputs settle by the falling edge
	task automatic ws(int c);
		w(c);
		@(negedge aclk);
	endtask
	task automatic axi_wr(logic [31:0] a, d, logic [1:0] er);
		logic aw = 1, wd = 1, bd = 1, ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (bd)
		begin
			@(negedge aclk);
			ta = aw && s_axi_awready;
			tw = wd && s_axi_wready;
			tb = s_axi_bvalid;
			if (tb)
				chk("bresp", er, s_axi_bresp);
			@(posedge aclk);
			aw = aw && !ta;
			wd = wd && !tw;
			bd = !tb;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, wd, bd};
		end
	endtask
	task automatic axi_rd(logic [31:0] a, e, logic [1:0] er);
		logic ar = 1, rd = 1, ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (rd)
		begin
			@(negedge aclk);
			ta = ar && s_axi_arready;
			tr = s_axi_rvalid;
			if (tr)
			begin
				chk("rdata", e, s_axi_rdata);
				chk("rresp", er, s_axi_rresp);
			end
			@(posedge aclk);
			ar = ar && !ta;
			rd = !tr;
			{s_axi_arvalid, s_axi_rready} <= {ar, rd};
		end
	endtask
	task automatic finish_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		ws(3);
		chk("rst_state", 1, {ready_out, intlk_open_out});
		w(1);
		aresetn <= 1;
		ws(10);
		chk("req_hold", 0, ready_out);
		w(1);
		hold_start <= 0;
		ws(6);
		chk("ready", 2, {ready_out_oe, rf_drive});
		ws(30);
		chk("emission_indicator", 3, {emission_indicator, emission_indicator_oe});
		chk("shut", 32'h0000_000E, {shutter_open, shutter_indicator,
			shutter_indicator_oe, intlk_open_out});
		axi_rd(`LUC_OFF_STAT, 32'h0000_009E, `LUC_RESP_OKAY);
		w(1);
		{pwm_cw, pwm_run} <= 2'h1;
		ws(10);
		n = 0;
		repeat (400)
		begin
			@(negedge aclk);
			if (rf_drive === 1'b1)
				n++;
		end
		chk("duty", 200, n);
		// Partner runs 100 high cycles in a 200-cycle period
		axi_rd(`LUC_OFF_PWM_HI, 32'h0000_0064, `LUC_RESP_OKAY);
		axi_rd(`LUC_OFF_PWM_PER, 32'h0000_00C8, `LUC_RESP_OKAY);
		w(1);
		{pwm_cw, pwm_run, shut_ok} <= 3'h4;
		ws(6);
		chk("shut_req", 1, {shutter_open, shutter_indicator, ready_out});
		w(1);
		{shut_ok, intlk_ok} <= 2'h2;
		ws(6);
		chk("loss", 1, {ready_out, shutter_open, rf_power_en, rf_drive,
			intlk_open_out_oe});
		w(1);
		intlk_ok <= 1;
		ws(15);
		chk("relatch", 2, {ready_out, rf_drive});
		w(1);
		intlk_ok <= 0;
		w(6);
		intlk_ok <= 1;
		ws(15);
		chk("restart", 2, {ready_out, rf_drive});
		ws(15);
		chk("resume", 3, {ready_out, rf_drive});
		w(1);
		overheat <= 1;
		ws(6);
		chk("hot", 1, overheat_indicator_oe);
		w(1);
		{overheat, no_strike} <= 2'h1;
		w(1);
		no_strike <= 0;
		ws(6);
		chk("strike", 1, overheat_indicator);
		axi_rd(`LUC_OFF_STAT, 32'h0000_00DE, `LUC_RESP_OKAY);
		axi_wr(`LUC_OFF_CTRL, 32'h0000_0001, `LUC_RESP_OKAY);
		ws(6);
		chk("clear", 0, overheat_indicator);
		axi_wr(`LUC_OFF_STAT, 32'hFFFF_FFFF, `LUC_RESP_OKAY);
		axi_rd(`LUC_OFF_STAT, 32'h0000_009E, `LUC_RESP_OKAY);
		axi_rd(32'h0000_0010, 32'h0000_0000, `LUC_RESP_SLVERR);
		axi_wr(32'h0000_0010, 32'h0000_0000, `LUC_RESP_SLVERR);
		axi_rd(`LUC_OFF_CTRL, 32'h0000_0000, `LUC_RESP_OKAY);
		finish_test;
	end
	// Whole sequence needs well under 2000 cycles
	initial
	begin
		w(5000);
		fail_count++;
		finish_test;
	end
endmodule // luc_top_tb
